// file: shared/serial_port_pkg.sv
package serial_port_pkg;

  // Word buffers
  localparam int        FIFO_WIDTH   = 16;
  localparam int        FIFO_DEPTH   = 8;
  localparam int        FIFO_AW      = 3;
  localparam logic [3:0] TX_LOW_LEVEL = 4'h4;
  localparam logic [3:0] RX_HIGH_LEVEL = 4'h4;

  // Idle bit periods before the receive time-out fires
  localparam logic [5:0] TIMEOUT_BITS = 6'h20;

  // Register byte offsets
  localparam logic [7:0] OFF_CONTROL_ZERO = 8'h00;
  localparam logic [7:0] OFF_CONTROL_ONE  = 8'h04;
  localparam logic [7:0] OFF_DATA         = 8'h08;
  localparam logic [7:0] OFF_STATUS       = 8'h0c;
  localparam logic [7:0] OFF_PRESCALE     = 8'h10;
  localparam logic [7:0] OFF_IRQ_ENABLE   = 8'h14;
  localparam logic [7:0] OFF_RAW_STATUS   = 8'h18;
  localparam logic [7:0] OFF_MASK_STATUS  = 8'h1c;
  localparam logic [7:0] OFF_INT_CLEAR    = 8'h20;
  localparam logic [7:0] OFF_DMA_CONTROL  = 8'h24;

  // Field positions
  localparam int SIZE_LSB    = 0;
  localparam int RATE_LSB    = 8;
  localparam int ENABLE_BIT  = 1;
  localparam int SLAVE_BIT   = 2;
  localparam int TXI_BIT     = 3;
  localparam int RXI_BIT     = 2;
  localparam int RTI_BIT     = 1;
  localparam int ORI_BIT     = 0;
  localparam int RT_CLR_BIT  = 1;
  localparam int OR_CLR_BIT  = 0;
  localparam int TX_DMA_BIT  = 1;
  localparam int RX_DMA_BIT  = 0;

  // Values after reset
  localparam logic [15:0] CONTROL_ZERO_RST = 16'h0007;
  localparam logic [2:0]  CONTROL_ONE_RST  = 3'h0;
  localparam logic [7:0]  PRESCALE_RST     = 8'h02;
  localparam logic [3:0]  IRQ_ENABLE_RST   = 4'h0;
  localparam logic [1:0]  DMA_CONTROL_RST  = 2'h0;

  // Shortest word is four bits, held as size minus one
  localparam logic [3:0] MIN_SIZE_M1 = 4'h3;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } bus_phase_t;

  typedef struct packed {
    logic [7:0] rate;
    logic [3:0] sizeM1;
    logic       enable;
    logic       slave;
  } port_cfg_t;

endpackage

// file: core/word_fifo.sv
`timescale 1ns/1ps
module word_fifo (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        push,
  input  wire logic [15:0] pushData,
  input  wire logic        pop,
  output logic      [15:0] popData,
  output logic             full,
  output logic             empty,
  output logic      [3:0]  count
);
  logic [15:0] mem [serial_port_pkg::FIFO_DEPTH];
  logic [2:0]  wrPtr;
  logic [2:0]  rdPtr;
  logic        doPush;
  logic        doPop;

  // A push into a full buffer succeeds only if a word leaves in the same cycle
  assign doPop  = pop && !empty;
  assign doPush = push && (!full || doPop);
  assign full   = (count == 4'h8);
  assign empty  = (count == 4'h0);
  assign popData = mem[rdPtr];

  always_ff @(posedge mclk) begin
    if (doPush) begin
      mem[wrPtr] <= pushData;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wrPtr <= 3'h0;
      rdPtr <= 3'h0;
      count <= 4'h0;
    end else begin
      if (doPush) begin
        wrPtr <= wrPtr + 3'h1;
      end
      if (doPop) begin
        rdPtr <= rdPtr + 3'h1;
      end
      count <= count + {3'h0, doPush} - {3'h0, doPop};
    end
  end
endmodule

// file: core/serial_port_core.sv
`timescale 1ns/1ps
// Functional notes
// - Writing one to timeout clear resets timeout flag
// - Writing one to overrun clear resets overrun flag
// - DMA control: tx enable bit1, rx bit0
// - Transmit FIFO sixteen bits, eight entries deep
// - Separate receive FIFO, sixteen bits, eight deep
// - Shift out on data-out, sample data-in
// - Master bit clock from two chained counters
// - First stage divides by even 2 to 254
// - Divisor least significant bit is ignored
// - Second stage divides by rate plus one
// - Transmit interrupt when four or fewer entries
// - Transmit interrupt also while port disabled
// - Receive interrupt when four or more entries
// - Timeout after 32 idle bits, FIFO non-empty
// - Timeout detection same in master and slave
// - Transfer start clears timeout if space remains
// - Transfer into full FIFO keeps timeout, overruns
// - Overrun when word arrives at full FIFO
// - Sources maskable, ORed into combined interrupt
// - Masked status equals raw status AND enable
// - Overrun discards words until overrun cleared
module serial_port_core (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        serialDataIn,
  output logic             serialDataOut,
  output logic             serialDataOutOe,
  input  wire logic        serialBitClockIn,
  output logic             serialBitClockOut,
  output logic             serialBitClockOe,
  output logic             combinedInterrupt,
  output logic             txDmaRequest,
  output logic             rxDmaRequest
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  function automatic logic [3:0] clampSize(input logic [3:0] s);
    clampSize = (s < serial_port_pkg::MIN_SIZE_M1) ? serial_port_pkg::MIN_SIZE_M1 : s;
  endfunction

  function automatic logic [15:0] sizeMask(input logic [3:0] s);
    sizeMask = 16'hffff >> (4'hf - s);
  endfunction

  serial_port_pkg::bus_phase_t dataPhase;
  serial_port_pkg::port_cfg_t  cfg;
  logic [15:0] controlZero;
  logic [2:0]  controlOne;
  logic [7:0]  prescaleReg;
  logic [3:0]  irqEnable;
  logic [1:0]  dmaControl;
  logic [3:0]  rawStatus;
  logic [3:0]  maskStatus;
  logic        addrValid;
  logic        wrEn;
  logic        rdDataNow;
  logic [31:0] next_hrdata;

  logic        txPush;
  logic        txPop;
  logic [15:0] txWord;
  logic        txFull;
  logic        txEmpty;
  logic [3:0]  txCount;
  logic        rxPush;
  logic        rxStore;
  logic        rxPop;
  logic [15:0] rxWord;
  logic        rxFull;
  logic        rxEmpty;
  logic [3:0]  rxCount;

  logic [6:0]  halfDiv;
  logic [6:0]  s1Cnt;
  logic        halfTick;
  logic [7:0]  s2Cnt;
  logic        edgeTick;
  logic        phase;
  logic        bitTick;
  logic        sclkPrev;
  logic        riseEvt;
  logic        fallEvt;
  logic        startNow;
  logic        active;
  logic        lastSampled;
  logic [3:0]  bitCnt;
  logic [15:0] shiftOut;
  logic [15:0] shiftIn;
  logic [5:0]  idleBits;

  logic        timeoutFlag;
  logic        timeoutSet;
  logic        timeoutClr;
  logic        overrunFlag;
  logic        overrunSet;
  logic        overrunClr;

  assign cfg.rate   = controlZero[serial_port_pkg::RATE_LSB +: 8];
  assign cfg.sizeM1 = clampSize(controlZero[serial_port_pkg::SIZE_LSB +: 4]);
  assign cfg.enable = controlOne[serial_port_pkg::ENABLE_BIT];
  assign cfg.slave  = controlOne[serial_port_pkg::SLAVE_BIT];

  // Zero wait states: read data is fetched at the address phase
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addrValid = hsel && htrans[1] && hready;
  assign wrEn      = dataPhase.valid && dataPhase.write;
  assign rdDataNow = addrValid && !hwrite && (haddr[7:0] == serial_port_pkg::OFF_DATA)
                     && (haddr[31:8] == 24'h0);

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      dataPhase <= '0;
    end else begin
      dataPhase.valid <= addrValid && (haddr[31:8] == 24'h0);
      dataPhase.write <= hwrite;
      dataPhase.addr  <= haddr[7:0];
    end
  end

  // Reserved bits are simply not stored
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      controlZero <= serial_port_pkg::CONTROL_ZERO_RST;
      controlOne  <= serial_port_pkg::CONTROL_ONE_RST;
      prescaleReg <= serial_port_pkg::PRESCALE_RST;
      irqEnable   <= serial_port_pkg::IRQ_ENABLE_RST;
      dmaControl  <= serial_port_pkg::DMA_CONTROL_RST;
    end else if (wrEn) begin
      case (dataPhase.addr)
        serial_port_pkg::OFF_CONTROL_ZERO: controlZero <= hwdata[15:0];
        serial_port_pkg::OFF_CONTROL_ONE:  controlOne  <= hwdata[2:0];
        serial_port_pkg::OFF_PRESCALE:     prescaleReg <= hwdata[7:0];
        serial_port_pkg::OFF_IRQ_ENABLE:   irqEnable   <= hwdata[3:0];
        serial_port_pkg::OFF_DMA_CONTROL:  dmaControl  <= hwdata[1:0];
        default: ;
      endcase
    end
  end

  assign txPush = wrEn && (dataPhase.addr == serial_port_pkg::OFF_DATA);
  // Clear strobes live one cycle and are never stored
  assign timeoutClr = wrEn && (dataPhase.addr == serial_port_pkg::OFF_INT_CLEAR)
                      && hwdata[serial_port_pkg::RT_CLR_BIT];
  assign overrunClr = wrEn && (dataPhase.addr == serial_port_pkg::OFF_INT_CLEAR)
                      && hwdata[serial_port_pkg::OR_CLR_BIT];
  assign rxPop = rdDataNow && !rxEmpty;

  always_comb begin
    next_hrdata = 32'h0;
    case (haddr[7:0])
      serial_port_pkg::OFF_CONTROL_ZERO: next_hrdata = {16'h0, controlZero};
      serial_port_pkg::OFF_CONTROL_ONE:  next_hrdata = {29'h0, controlOne};
      serial_port_pkg::OFF_DATA:         next_hrdata = {16'h0, rxWord};
      serial_port_pkg::OFF_STATUS:       next_hrdata = {19'h0, active, rxCount, txCount,
                                                        rxFull, !rxEmpty, !txFull, txEmpty};
      serial_port_pkg::OFF_PRESCALE:     next_hrdata = {24'h0, prescaleReg};
      serial_port_pkg::OFF_IRQ_ENABLE:   next_hrdata = {28'h0, irqEnable};
      serial_port_pkg::OFF_RAW_STATUS:   next_hrdata = {28'h0, rawStatus};
      serial_port_pkg::OFF_MASK_STATUS:  next_hrdata = {28'h0, maskStatus};
      serial_port_pkg::OFF_DMA_CONTROL:  next_hrdata = {30'h0, dmaControl};
      default:                           next_hrdata = 32'h0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      hrdata <= 32'h0;
    end else if (addrValid && !hwrite) begin
      hrdata <= (haddr[31:8] == 24'h0) ? next_hrdata : 32'h0;
    end
  end

  word_fifo txFifo (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .push     (txPush),
    .pushData (hwdata[15:0]),
    .pop      (txPop),
    .popData  (txWord),
    .full     (txFull),
    .empty    (txEmpty),
    .count    (txCount)
  );

  word_fifo rxFifo (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .push     (rxStore),
    .pushData (shiftIn & sizeMask(cfg.sizeM1)),
    .pop      (rxPop),
    .popData  (rxWord),
    .full     (rxFull),
    .empty    (rxEmpty),
    .count    (rxCount)
  );

  // Stage one counts half the even divisor, so each half bit is a whole cycle count
  assign halfDiv  = (prescaleReg[7:1] == 7'h0) ? 7'h1 : prescaleReg[7:1];
  assign halfTick = (s1Cnt >= halfDiv - 7'h1);
  assign edgeTick = halfTick && (s2Cnt >= cfg.rate);
  assign bitTick  = edgeTick && phase;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s1Cnt <= 7'h0;
    end else begin
      s1Cnt <= halfTick ? 7'h0 : s1Cnt + 7'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s2Cnt <= 8'h0;
      phase <= 1'b0;
    end else if (halfTick) begin
      s2Cnt <= edgeTick ? 8'h0 : s2Cnt + 8'h1;
      phase <= edgeTick ? !phase : phase;
    end
  end

  // The input pin is taken as synchronous, so one register finds its edges
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sclkPrev <= 1'b0;
    end else begin
      sclkPrev <= serialBitClockIn;
    end
  end

  always_comb begin
    riseEvt = cfg.slave ? (serialBitClockIn && !sclkPrev) : (edgeTick && !phase);
    fallEvt = cfg.slave ? (!serialBitClockIn && sclkPrev) : (edgeTick && phase);
    if (!cfg.enable) begin
      startNow = 1'b0;
    end else if (cfg.slave) begin
      startNow = riseEvt && !active;
    end else begin
      startNow = fallEvt && !txEmpty && (!active || lastSampled);
    end
  end

  // A slave with nothing queued sends zeros
  assign txPop = startNow && !txEmpty;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      active      <= 1'b0;
      lastSampled <= 1'b0;
      bitCnt      <= 4'h0;
      shiftOut    <= 16'h0;
      shiftIn     <= 16'h0;
      rxPush      <= 1'b0;
    end else begin
      rxPush <= 1'b0;
      if (!cfg.enable) begin
        active      <= 1'b0;
        lastSampled <= 1'b0;
      end else begin
        if (startNow) begin
          shiftOut    <= (txEmpty ? 16'h0 : txWord) << (4'hf - cfg.sizeM1);
          active      <= 1'b1;
          lastSampled <= 1'b0;
          bitCnt      <= 4'h0;
        end else if (fallEvt && active) begin
          if (lastSampled) begin
            active      <= 1'b0;
            lastSampled <= 1'b0;
          end else begin
            shiftOut <= {shiftOut[14:0], 1'b0};
          end
        end
        if (riseEvt && (active || startNow) && !(lastSampled && !startNow)) begin
          shiftIn <= startNow ? {15'h0, serialDataIn} : {shiftIn[14:0], serialDataIn};
          bitCnt  <= startNow ? 4'h1 : bitCnt + 4'h1;
          if ((startNow ? 4'h0 : bitCnt) == cfg.sizeM1) begin
            lastSampled <= 1'b1;
            rxPush      <= 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      serialDataOut     <= 1'b0;
      serialDataOutOe   <= 1'b0;
      serialBitClockOut <= 1'b0;
      serialBitClockOe  <= 1'b0;
    end else begin
      serialDataOut     <= shiftOut[15];
      serialDataOutOe   <= cfg.enable && (active || startNow);
      serialBitClockOut <= cfg.enable && !cfg.slave && active && phase;
      serialBitClockOe  <= cfg.enable && !cfg.slave;
    end
  end

  // Reading the FIFO in the finishing cycle frees a slot and saves the word
  assign rxStore    = rxPush && !overrunFlag && (!rxFull || rxPop);
  assign overrunSet = rxPush && rxFull && !rxPop;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      overrunFlag <= 1'b0;
    end else if (overrunSet) begin
      overrunFlag <= 1'b1;
    end else if (overrunClr) begin
      overrunFlag <= 1'b0;
    end
  end

  // Same free-running bit period serves master and slave alike
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      idleBits <= 6'h0;
    end else if (active || rxEmpty || rxPop) begin
      idleBits <= 6'h0;
    end else if (bitTick && idleBits < serial_port_pkg::TIMEOUT_BITS) begin
      idleBits <= idleBits + 6'h1;
    end
  end

  assign timeoutSet = bitTick && !active && !rxEmpty && !rxPop
                      && (idleBits == serial_port_pkg::TIMEOUT_BITS - 6'h1);

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      timeoutFlag <= 1'b0;
    end else if (timeoutSet) begin
      timeoutFlag <= 1'b1;
    end else if (timeoutClr || (startNow && !rxFull)) begin
      timeoutFlag <= 1'b0;
    end
  end

  always_comb begin
    rawStatus = 4'h0;
    rawStatus[serial_port_pkg::TXI_BIT] = (txCount <= serial_port_pkg::TX_LOW_LEVEL)
                                          || !cfg.enable;
    rawStatus[serial_port_pkg::RXI_BIT] = (rxCount >= serial_port_pkg::RX_HIGH_LEVEL);
    rawStatus[serial_port_pkg::RTI_BIT] = timeoutFlag;
    rawStatus[serial_port_pkg::ORI_BIT] = overrunFlag;
  end

  assign maskStatus        = rawStatus & irqEnable;
  assign combinedInterrupt = |maskStatus;

  // Plain level requests; the controller's clear handshake is not modelled
  assign txDmaRequest = cfg.enable && dmaControl[serial_port_pkg::TX_DMA_BIT]
                        && rawStatus[serial_port_pkg::TXI_BIT];
  assign rxDmaRequest = cfg.enable && dmaControl[serial_port_pkg::RX_DMA_BIT]
                        && rawStatus[serial_port_pkg::RXI_BIT];

  sequence wordIntoFull;
    rxPush && rxFull && !rxPop;
  endsequence

  sequence clearTimeoutOnly;
    timeoutClr && !timeoutSet;
  endsequence

  timeout_clear_a: assert property (clearTimeoutOnly |=> !timeoutFlag)
    else $error("timeout flag not cleared");
  overrun_clear_a: assert property (overrunClr && !overrunSet |=> !overrunFlag)
    else $error("overrun flag not cleared");
  overrun_set_a: assert property (wordIntoFull |=> overrunFlag && $stable(rxCount))
    else $error("overrun missed or word stored");
  overrun_drop_a: assert property (overrunFlag && rxPush && !rxPop |=> $stable(rxCount))
    else $error("word stored during overrun");
  tx_level_a: assert property (!cfg.enable |-> rawStatus[serial_port_pkg::TXI_BIT])
    else $error("transmit condition wrong at disable");
  irq_combine_a: assert property (combinedInterrupt == |(rawStatus & irqEnable))
    else $error("combined interrupt mismatch");
  // A divisor lowered mid-count overshoots for one cycle, so that cycle is let pass
  prescale_range_a: assert property (halfTick && $stable(prescaleReg)
                                     |-> s1Cnt == halfDiv - 7'h1)
    else $error("first stage period wrong");
  timeout_set_a: assert property (timeoutSet |=> timeoutFlag)
    else $error("timeout not raised");
  start_clear_a: assert property (startNow && !rxFull && !timeoutSet |=> !timeoutFlag)
    else $error("transfer start kept timeout");
  full_keep_a: assert property (startNow && rxFull && timeoutFlag && !timeoutClr
                                |=> timeoutFlag)
    else $error("timeout lost on full start");
  rx_level_a: assert property (rxCount >= 4'h4 |-> rawStatus[2] ##1 rawStatus[2] || rxPop
                               || $past(rxPop))
    else $error("receive condition missing");
endmodule

// file: verification/serial_peripheral_model.sv
`timescale 1ns/1ps
module serial_peripheral_model (
  input  wire logic serialBitClock,
  input  wire logic serialDataOut,
  input  wire logic serialDataOutOe,
  output logic      serialDataIn
);
  // Wired loopback device: each driven bit comes back, so received words equal sent ones in the master stream test
  logic lastBit = 1'b0;

  always @(posedge serialBitClock) begin
    if (serialDataOutOe) begin
      lastBit <= serialDataOut;
    end
  end

  // A released line shows the inverse of the last bit, so a stale value never passes
  assign serialDataIn = serialDataOutOe ? serialDataOut : ~lastBit;
endmodule

// file: verification/tb_sync_serial_fifo_irq_prescaler.sv
`timescale 1ns/1ps
`define CHK(got, want) begin checked++; if ((got) !== (want)) begin errors++; \
  $display("unexpected at %0t: got %h want %h", $time, got, want); end end
module tb_sync_serial_fifo_irq_prescaler;
  logic        mclk;
  logic        rst_b;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        serialDataIn;
  logic        serialDataOut;
  logic        serialDataOutOe;
  logic        serialBitClockOut;
  logic        serialBitClockOe;
  logic        combinedInterrupt;
  logic        txDmaRequest;
  logic        rxDmaRequest;
  int          errors;
  int          checked;
  logic [31:0] rdData;
  logic        irqSnap;
  logic        slaveClk;
  logic [15:0] sent [8];

  serial_port_core serial_port_core_inst (
    .mclk              (mclk),
    .rst_b             (rst_b),
    .hsel              (1'b1),
    .haddr             (haddr),
    .htrans            (htrans),
    .hwrite            (hwrite),
    .hsize             (3'h2),
    .hwdata            (hwdata),
    .hready            (hreadyout),
    .hreadyout         (hreadyout),
    .hresp             (hresp),
    .hrdata            (hrdata),
    .serialDataIn      (serialDataIn),
    .serialDataOut     (serialDataOut),
    .serialDataOutOe   (serialDataOutOe),
    .serialBitClockIn  (slaveClk),
    .serialBitClockOut (serialBitClockOut),
    .serialBitClockOe  (serialBitClockOe),
    .combinedInterrupt (combinedInterrupt),
    .txDmaRequest      (txDmaRequest),
    .rxDmaRequest      (rxDmaRequest)
  );

  serial_peripheral_model serial_peripheral_model_inst (
    .serialBitClock  (serialBitClockOe ? serialBitClockOut : slaveClk),
    .serialDataOut   (serialDataOut),
    .serialDataOutOe (serialDataOutOe),
    .serialDataIn    (serialDataIn)
  );

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic end_sim;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
  endtask

  // The interrupt is sampled at the address edge, the same state that status is read from
  task automatic rd(input logic [7:0] a);
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    irqSnap = combinedInterrupt;
    htrans <= 2'h0;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rdData = hrdata;
  endtask

  task automatic check_raw(input logic [3:0] want);
    rd(serial_port_pkg::OFF_RAW_STATUS);
    `CHK(rdData[3:0], want)
  endtask

  task automatic rst_dut;
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
  endtask

  task automatic setup(input logic [7:0] psc, input logic [7:0] rate);
    rst_dut();
    wr(serial_port_pkg::OFF_PRESCALE, {24'h0, psc});
    wr(serial_port_pkg::OFF_CONTROL_ZERO, {16'h0, rate, 8'h0f});
  endtask

  task automatic test_regs;
    rst_dut();
    rd(serial_port_pkg::OFF_DMA_CONTROL);
    `CHK(rdData[1:0], 2'h0)
    check_raw(4'h8);
    rd(serial_port_pkg::OFF_MASK_STATUS);
    `CHK(rdData[3:0], 4'h0)
    wr(serial_port_pkg::OFF_IRQ_ENABLE, 32'h8);
    rd(serial_port_pkg::OFF_MASK_STATUS);
    `CHK(rdData[3:0], 4'h8)
    `CHK(combinedInterrupt, 1'b1)
    wr(serial_port_pkg::OFF_DMA_CONTROL, 32'hffff_ffff);
    rd(serial_port_pkg::OFF_DMA_CONTROL);
    `CHK(rdData, 32'h3)
    `CHK(hresp, 1'b0)
    wr(serial_port_pkg::OFF_DMA_CONTROL, 32'h1);
    rd(serial_port_pkg::OFF_DMA_CONTROL);
    `CHK(rdData, 32'h1)
    rd(serial_port_pkg::OFF_INT_CLEAR);
    `CHK(rdData, 32'h0)
    rd(8'h40);
    `CHK(rdData, 32'h0)
    $display("test regs done");
  endtask

  task automatic test_rate;
    logic [7:0] psc [3] = '{8'h08, 8'h05, 8'h02};
    logic [7:0] rate [3] = '{8'h00, 8'h02, 8'h00};
    int         expPeriod [3] = '{8, 12, 2};
    int         cnt;
    for (int i = 0; i < 3; i++) begin
      setup(psc[i], rate[i]);
      wr(serial_port_pkg::OFF_DATA, 32'h1234);
      wr(serial_port_pkg::OFF_CONTROL_ONE, 32'h2);
      while (serialBitClockOut !== 1'b1) @(posedge mclk);
      while (serialBitClockOut === 1'b1) @(posedge mclk);
      cnt = 0;
      while (serialBitClockOut !== 1'b1) begin
        @(posedge mclk);
        cnt++;
      end
      while (serialBitClockOut === 1'b1) begin
        @(posedge mclk);
        cnt++;
      end
      `CHK(cnt, expPeriod[i])
      `CHK(serialBitClockOe, 1'b1)
    end
    $display("test rate done");
  endtask

  task automatic test_stream;
    setup(8'h08, 8'h00);
    wr(serial_port_pkg::OFF_IRQ_ENABLE, 32'hc);
    wr(serial_port_pkg::OFF_DMA_CONTROL, 32'h3);
    for (int i = 0; i < 8; i++) begin
      sent[i] = 16'h0a5c + 16'h1357 * i[15:0];
      wr(serial_port_pkg::OFF_DATA, {16'h0, sent[i]});
    end
    wr(serial_port_pkg::OFF_DATA, 32'hdead);
    rd(serial_port_pkg::OFF_STATUS);
    `CHK(rdData[7:4], 4'h8)
    `CHK(rdData[1], 1'b0)
    // Eight words queued, so only the disabled port can raise the transmit condition
    check_raw(4'h8);
    wr(serial_port_pkg::OFF_CONTROL_ONE, 32'h2);
    do begin
      rd(serial_port_pkg::OFF_STATUS);
      `CHK(irqSnap, (rdData[7:4] <= 4'h4) | (rdData[11:8] >= 4'h4))
    end while (rdData[0] !== 1'b1 || rdData[12] !== 1'b0);
    repeat (4) @(posedge mclk);
    check_raw(4'hc);
    repeat (280) @(posedge mclk);
    check_raw(4'he);
    wr(serial_port_pkg::OFF_DATA, 32'hbeef);
    repeat (200) @(posedge mclk);
    check_raw(4'hf);
    wr(serial_port_pkg::OFF_INT_CLEAR, 32'hffff_fffc);
    check_raw(4'hf);
    wr(serial_port_pkg::OFF_INT_CLEAR, 32'h2);
    check_raw(4'hd);
    wr(serial_port_pkg::OFF_INT_CLEAR, 32'h1);
    check_raw(4'hc);
    `CHK({txDmaRequest, rxDmaRequest}, 2'h3)
    for (int i = 0; i < 8; i++) begin
      rd(serial_port_pkg::OFF_DATA);
      `CHK(rdData[15:0], sent[i])
    end
    check_raw(4'h8);
    `CHK({txDmaRequest, rxDmaRequest}, 2'h2)
    $display("test stream done");
  endtask

  task automatic test_timeout_clear;
    setup(8'h08, 8'h00);
    wr(serial_port_pkg::OFF_CONTROL_ONE, 32'h2);
    wr(serial_port_pkg::OFF_DATA, 32'h00f0);
    repeat (250) @(posedge mclk);
    check_raw(4'h8);
    repeat (200) @(posedge mclk);
    check_raw(4'ha);
    wr(serial_port_pkg::OFF_DATA, 32'h0f00);
    repeat (40) @(posedge mclk);
    check_raw(4'h8);
    $display("test timeout clear done");
  endtask

  // Slave clock of twelve cycles, the fastest a slave may be driven
  task automatic test_slave;
    setup(8'h08, 8'h00);
    wr(serial_port_pkg::OFF_CONTROL_ONE, 32'h6);
    for (int i = 0; i < 16; i++) begin
      slaveClk <= 1'b1;
      repeat (6) @(posedge mclk);
      slaveClk <= 1'b0;
      repeat (6) @(posedge mclk);
    end
    `CHK(serialBitClockOe, 1'b0)
    check_raw(4'h8);
    repeat (300) @(posedge mclk);
    check_raw(4'ha);
    $display("test slave done");
  endtask

  // Whole run needs about 3000 cycles; the margin covers a slow bit clock
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    end_sim();
  end

  initial begin
    rst_b   = 1'b0;
    haddr   = 32'h0;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    hwdata  = 32'h0;
    slaveClk = 1'b0;
    errors  = 0;
    checked = 0;
    @(posedge mclk);
    test_regs();
    test_rate();
    test_stream();
    test_timeout_clear();
    test_slave();
    end_sim();
  end
endmodule
